// ==== hdl/ean_top.sv ====
// Purpose: per-phase energy accumulation with sign modes and no-load detect
// Assumes: power samples and strobes come from logic on sys_clk
// Notes:   APB slave with one wait state; all outputs registered
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// - active mode: signed, absolute, positive, negative
// - signed active energy sign in top bit
// - reactive mode covers total and fundamental reactive
// - signed reactive energy sign in top bit
// - no-load judged per phase and energy
// - window field: 64..4096 samples, seven disables
// - reset: detection on, 64-sample window
// - three thresholds: active, reactive, apparent
// - no-load lane adds zero to energy
// - power accumulators never gated by no-load
// - status bits per phase: apparent, reactive, active
// - change flag per energy type, enables interrupt
// - event pin optionally shows no-load status
// - 42-bit signed energy accumulator, per sample
// - update event loads or adds, then restarts
module ean_top
	import ean_pkg::*;
(
	// clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	// apb slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [7:0]                      paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// dsp samples, one phase per slice
	input  wire logic                            sample_strobe,
	input  wire logic                            energy_update,
	input  wire logic [ean_pkg::PHASES-1:0][ean_pkg::POWER_W-1:0] active_power,
	input  wire logic [ean_pkg::PHASES-1:0][ean_pkg::POWER_W-1:0] reactive_power,
	input  wire logic [ean_pkg::PHASES-1:0][ean_pkg::POWER_W-1:0] apparent_power,
	input  wire logic [ean_pkg::PHASES-1:0][ean_pkg::POWER_W-1:0] fund_reactive_power,
	// indications
	output logic                                 interrupt_out_one,
	output logic                                 event_out_n
);
	import ean_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// configuration and status state
	logic [3:0]        accumulation_mode_config;
	logic              load_or_add_select;
	logic [2:0]        noload_window_select;
	logic              event_noload_en;
	logic [31:0]       active_noload_threshold;
	logic [31:0]       reactive_noload_threshold;
	logic [31:0]       apparent_noload_threshold;
	logic [TYPES-1:0]  second_status_word;
	logic [TYPES-1:0]  irq_mask;
	logic [LANES-1:0]  noload_prev;
	logic [WCNT_W-1:0] win_cnt;

	logic [3:0]        next_accumulation_mode_config;
	logic              next_load_or_add_select;
	logic [2:0]        next_noload_window_select;
	logic              next_event_noload_en;
	logic [31:0]       next_active_noload_threshold;
	logic [31:0]       next_reactive_noload_threshold;
	logic [31:0]       next_apparent_noload_threshold;
	logic [TYPES-1:0]  next_second_status_word;
	logic [TYPES-1:0]  next_irq_mask;
	logic [WCNT_W-1:0] next_win_cnt;
	logic [31:0]       next_prdata;
	logic              next_pready;
	logic              next_pslverr;
	logic              next_interrupt_out_one;
	logic              next_event_out_n;

	//////////////////////////////////////////////////////////////////////
	// lane wiring
	logic [LANES-1:0]                       lane_noload;
	logic signed [LANES-1:0][USER_W-1:0]    lane_user;
	logic signed [LANES-1:0][ENERGY_W-1:0]  lane_pacc;
	logic [LANES-1:0][POWER_W-1:0]          lane_power;
	ean_mode_t                              active_mode;
	ean_mode_t                              reactive_mode;
	logic              window_off;
	logic              window_end;
	logic [WCNT_W-1:0] win_last;
	logic [TYPES-1:0]  type_change;
	logic [31:0]       noload_status_word;
	logic              wr_go;
	logic [31:0]       w1c;

	assign active_mode   = ean_mode_t'(accumulation_mode_config[ACT_MODE_LSB+:2]);
	assign reactive_mode = ean_mode_t'(accumulation_mode_config[REACT_MODE_LSB+:2]);
	assign window_off = (noload_window_select == WINDOW_OFF);
	assign win_last   = WCNT_W'((NL_BASE_SAMPLES << noload_window_select)
		- 13'h0001);
	// a shorter window chosen mid-count ends at the next strobe, not on wrap
	assign window_end = sample_strobe && !window_off && (win_cnt >= win_last);

	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++)
		begin : g_lane
			localparam int TY = gi / PHASES;
			localparam int PH = gi % PHASES;
			ean_mode_t   mode;
			logic [31:0] thresh;

			always_comb
			begin
				case (TY)
					TYPE_ACTIVE:
					begin
						mode   = active_mode;
						thresh = active_noload_threshold;
						lane_power[gi] = active_power[PH];
					end
					TYPE_REACTIVE:
					begin
						mode   = reactive_mode;
						thresh = reactive_noload_threshold;
						lane_power[gi] = reactive_power[PH];
					end
					TYPE_APPARENT:
					begin
						// apparent power is never negative; signed is exact
						mode   = EAN_SIGNED;
						thresh = apparent_noload_threshold;
						lane_power[gi] = apparent_power[PH];
					end
					default:
					begin
						mode   = reactive_mode;
						thresh = reactive_noload_threshold;
						lane_power[gi] = fund_reactive_power[PH];
					end
				endcase
			end

			ean_lane u_lane (
				.sys_clk       (sys_clk),
				.rst           (rst),
				.sample_strobe (sample_strobe),
				.window_end    (window_end),
				.window_off    (window_off),
				.update        (energy_update),
				.power         (lane_power[gi]),
				.mode          (mode),
				.threshold     (thresh),
				.window_sel    (noload_window_select),
				.load_sel      (load_or_add_select),
				.noload        (lane_noload[gi]),
				.user_energy   (lane_user[gi]),
				.power_accum   (lane_pacc[gi])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// status layout: phase p uses bits 3p+2..3p, fundamental at 9+p
	always_comb
	begin
		noload_status_word = 32'h0000_0000;
		for (int p = 0; p < PHASES; p++)
		begin
			noload_status_word[3*p+0] = lane_noload[TYPE_ACTIVE*PHASES+p];
			noload_status_word[3*p+1] = lane_noload[TYPE_REACTIVE*PHASES+p];
			noload_status_word[3*p+2] = lane_noload[TYPE_APPARENT*PHASES+p];
			noload_status_word[FUND_STAT_LSB+p] =
				lane_noload[TYPE_FUND_REACTIVE*PHASES+p];
		end
		for (int t = 0; t < TYPES; t++)
			type_change[t] = |(lane_noload[t*PHASES+:PHASES]
				^ noload_prev[t*PHASES+:PHASES]);
	end

	//////////////////////////////////////////////////////////////////////
	// apb access and register writes
	always_comb
	begin
		wr_go = psel && penable && pready && pwrite;
		w1c   = (wr_go && paddr == OFS_STATUS_TWO) ? pwdata : 32'h0000_0000;
		next_accumulation_mode_config  = accumulation_mode_config;
		next_load_or_add_select        = load_or_add_select;
		next_noload_window_select      = noload_window_select;
		next_event_noload_en           = event_noload_en;
		next_active_noload_threshold   = active_noload_threshold;
		next_reactive_noload_threshold = reactive_noload_threshold;
		next_apparent_noload_threshold = apparent_noload_threshold;
		next_irq_mask                  = irq_mask;
		if (wr_go)
		begin
			case (paddr)
				OFS_ACCUM_MODE:
					next_accumulation_mode_config = pwdata[3:0];
				OFS_EP_CONFIG:
				begin
					next_load_or_add_select   = pwdata[LOAD_SEL_BIT];
					next_noload_window_select = pwdata[WINDOW_SEL_LSB+:3];
					next_event_noload_en      = pwdata[EVENT_EN_BIT];
				end
				OFS_ACT_THRESH:   next_active_noload_threshold   = pwdata;
				OFS_REACT_THRESH: next_reactive_noload_threshold = pwdata;
				OFS_APP_THRESH:   next_apparent_noload_threshold = pwdata;
				OFS_IRQ_MASK:     next_irq_mask = pwdata[TYPES-1:0];
				default:          next_irq_mask = irq_mask;
			endcase
		end
		// a change in the clearing cycle keeps its flag set
		next_second_status_word = (second_status_word & ~w1c[TYPES-1:0])
			| type_change;
		next_interrupt_out_one = |(next_second_status_word & next_irq_mask);
		next_event_out_n = !(next_event_noload_en && |lane_noload);
		// window counter restarts at each window end
		if (window_off || window_end)
			next_win_cnt = '0;
		else if (sample_strobe)
			next_win_cnt = win_cnt + 1'b1;
		else
			next_win_cnt = win_cnt;
	end

	//////////////////////////////////////////////////////////////////////
	// read mux; one wait state so prdata leaves a flop
	always_comb
	begin
		next_pready  = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (next_pready)
		begin
			case (paddr)
				OFS_ACCUM_MODE:
					next_prdata = {28'h000_0000, accumulation_mode_config};
				OFS_EP_CONFIG:
					next_prdata = {27'h000_0000, event_noload_en,
						noload_window_select, load_or_add_select};
				OFS_ACT_THRESH:   next_prdata = active_noload_threshold;
				OFS_REACT_THRESH: next_prdata = reactive_noload_threshold;
				OFS_APP_THRESH:   next_prdata = apparent_noload_threshold;
				OFS_NOLOAD_STAT:  next_prdata = noload_status_word;
				OFS_STATUS_TWO:
					next_prdata = {28'h000_0000, second_status_word};
				OFS_IRQ_MASK:     next_prdata = {28'h000_0000, irq_mask};
				OFS_A_ACT_HIGH:
					next_prdata = lane_user[TYPE_ACTIVE*PHASES]
						[USER_W-1:USER_HI_LSB];
				OFS_A_REACT_HIGH:
					next_prdata = lane_user[TYPE_REACTIVE*PHASES]
						[USER_W-1:USER_HI_LSB];
				OFS_A_ACT_PACC:
					next_prdata = lane_pacc[TYPE_ACTIVE*PHASES]
						[ENERGY_W-1:ENERGY_W-32];
				default:          next_pslverr = 1'b1;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			accumulation_mode_config  <= ACCUM_MODE_RST;
			load_or_add_select        <= 1'b0;
			noload_window_select      <= WINDOW_SEL_RST;
			event_noload_en           <= 1'b0;
			active_noload_threshold   <= THRESH_RST;
			reactive_noload_threshold <= THRESH_RST;
			apparent_noload_threshold <= THRESH_RST;
			second_status_word        <= '0;
			irq_mask                  <= '0;
			noload_prev               <= '0;
			win_cnt                   <= '0;
			prdata                    <= 32'h0000_0000;
			pready                    <= 1'b0;
			pslverr                   <= 1'b0;
			interrupt_out_one         <= 1'b0;
			event_out_n               <= 1'b1;
		end
		else
		begin
			accumulation_mode_config  <= next_accumulation_mode_config;
			load_or_add_select        <= next_load_or_add_select;
			noload_window_select      <= next_noload_window_select;
			event_noload_en           <= next_event_noload_en;
			active_noload_threshold   <= next_active_noload_threshold;
			reactive_noload_threshold <= next_reactive_noload_threshold;
			apparent_noload_threshold <= next_apparent_noload_threshold;
			second_status_word        <= next_second_status_word;
			irq_mask                  <= next_irq_mask;
			noload_prev               <= lane_noload;
			win_cnt                   <= next_win_cnt;
			prdata                    <= next_prdata;
			pready                    <= next_pready;
			pslverr                   <= next_pslverr;
			interrupt_out_one         <= next_interrupt_out_one;
			event_out_n               <= next_event_out_n;
		end
	end

endmodule : ean_top
`default_nettype wire

// ==== hdl/ean_pkg.sv ====
// Purpose: shared constants for the energy accumulation / no-load block
// Assumes: 32-bit APB register words, 4 kSPS sample strobe on sys_clk
// Notes:   register offsets are byte addresses
package ean_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int POWER_W  = 32;
	localparam int ENERGY_W = 42;
	localparam int USER_W   = 45;
	localparam int USER_HI_LSB = 13;
	localparam int PHASES   = 3;
	localparam int TYPES    = 4;
	localparam int LANES    = PHASES * TYPES;
	localparam int WCNT_W   = 12;

	////////////////////////////////////////////////////////////////////////
	// energy type indices
	localparam int TYPE_ACTIVE   = 0;
	localparam int TYPE_REACTIVE = 1;
	localparam int TYPE_APPARENT = 2;
	localparam int TYPE_FUND_REACTIVE = 3;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_ACCUM_MODE   = 8'h00;
	localparam logic [7:0] OFS_EP_CONFIG    = 8'h04;
	localparam logic [7:0] OFS_ACT_THRESH   = 8'h08;
	localparam logic [7:0] OFS_REACT_THRESH = 8'h0C;
	localparam logic [7:0] OFS_APP_THRESH   = 8'h10;
	localparam logic [7:0] OFS_NOLOAD_STAT  = 8'h14;
	localparam logic [7:0] OFS_STATUS_TWO   = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h1C;
	localparam logic [7:0] OFS_A_ACT_HIGH   = 8'h20;
	localparam logic [7:0] OFS_A_REACT_HIGH = 8'h24;
	localparam logic [7:0] OFS_A_ACT_PACC   = 8'h28;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int ACT_MODE_LSB    = 0;
	localparam int REACT_MODE_LSB  = 2;
	localparam int LOAD_SEL_BIT    = 0;
	localparam int WINDOW_SEL_LSB  = 1;
	localparam int EVENT_EN_BIT    = 4;
	localparam int FUND_STAT_LSB   = 9;

	////////////////////////////////////////////////////////////////////////
	// reset values and counts
	localparam logic [3:0]  ACCUM_MODE_RST = 4'h0;
	localparam logic [2:0]  WINDOW_SEL_RST = 3'h0;
	localparam logic [2:0]  WINDOW_OFF     = 3'h7;
	localparam logic [31:0] THRESH_RST     = 32'h0000_0000;
	localparam logic [12:0] NL_BASE_SAMPLES = 13'h0040;

	typedef enum logic [1:0] {
		EAN_SIGNED,
		EAN_ABSOLUTE,
		EAN_POS_ONLY,
		EAN_NEG_ONLY
	} ean_mode_t;

endpackage : ean_pkg

// ==== hdl/ean_lane.sv ====
// Purpose: one phase/energy lane: energy, window and power accumulators
// Assumes: sample_strobe one cycle per 4 kSPS sample
// Notes:   window_end coincides with a sample strobe
`timescale 1ns/1ps
`default_nettype none
module ean_lane
	import ean_pkg::*;
(
	// clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              rst,
	// timing
	input  wire logic                              sample_strobe,
	input  wire logic                              window_end,
	input  wire logic                              window_off,
	input  wire logic                              update,
	// configuration
	input  wire logic signed [ean_pkg::POWER_W-1:0] power,
	input  wire ean_pkg::ean_mode_t                mode,
	input  wire logic        [31:0]                threshold,
	input  wire logic        [2:0]                 window_sel,
	input  wire logic                              load_sel,
	// results
	output logic                                   noload,
	output logic signed      [ean_pkg::USER_W-1:0] user_energy,
	output logic signed      [ean_pkg::ENERGY_W-1:0] power_accum
);
	logic signed [ENERGY_W-1:0] energy;
	logic signed [ENERGY_W-1:0] win;
	logic signed [ENERGY_W-1:0] next_energy;
	logic signed [ENERGY_W-1:0] next_win;
	logic signed [ENERGY_W-1:0] next_power_accum;
	logic signed [USER_W-1:0]   next_user_energy;
	logic                       next_noload;
	logic signed [ENERGY_W-1:0] p_ext;
	logic signed [ENERGY_W-1:0] sel_val;
	logic signed [ENERGY_W-1:0] contrib;
	logic signed [ENERGY_W-1:0] win_sum;
	logic        [ENERGY_W-1:0] win_mag;
	logic        [ENERGY_W-1:0] limit;

	always_comb
	begin
		p_ext = ENERGY_W'(power);
		case (mode)
			EAN_SIGNED:   sel_val = p_ext;
			EAN_ABSOLUTE: sel_val = (p_ext < 0) ? -p_ext : p_ext;
			EAN_POS_ONLY: sel_val = (p_ext > 0) ? p_ext : '0;
			EAN_NEG_ONLY: sel_val = (p_ext < 0) ? p_ext : '0;
			default:      sel_val = p_ext;
		endcase
		// no-load lanes add zero to energy, never to power
		contrib = noload ? '0 : sel_val;
		next_energy = energy;
		if (update)
			next_energy = sample_strobe ? contrib : '0;
		else if (sample_strobe)
			next_energy = energy + contrib;
		next_user_energy = user_energy;
		if (update)
			next_user_energy = load_sel ? USER_W'(energy)
				: user_energy + USER_W'(energy);
		next_power_accum = power_accum;
		if (sample_strobe)
			next_power_accum = power_accum + p_ext;
		// threshold is per 64 samples, so it scales with the window
		win_sum = win + sel_val;
		win_mag = (win_sum < 0) ? ENERGY_W'(-win_sum) : ENERGY_W'(win_sum);
		limit = ENERGY_W'(threshold) << window_sel;
		next_win = win;
		next_noload = noload;
		if (window_off)
		begin
			next_win = '0;
			next_noload = 1'b0;
		end
		else if (window_end)
		begin
			next_win = '0;
			next_noload = (win_mag < limit);
		end
		else if (sample_strobe)
			next_win = win_sum;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			energy      <= '0;
			win         <= '0;
			power_accum <= '0;
			user_energy <= '0;
			noload      <= 1'b0;
		end
		else
		begin
			energy      <= next_energy;
			win         <= next_win;
			power_accum <= next_power_accum;
			user_energy <= next_user_energy;
			noload      <= next_noload;
		end
	end

endmodule : ean_lane
`default_nettype wire

// ==== tb/ean_top_props.sv ====
// Purpose: port-level checker for the energy accumulation / no-load block
// Assumes: apb master holds each request until pready
// Notes:   bound to ean_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ean_top_props
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// indications
	input wire logic        interrupt_out_one,
	input wire logic        event_out_n
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	a_apb_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not two cycles after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_err_read_zero: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
		else $error("error response malformed");
	a_err_unmapped: assert property (pready && (paddr > ean_pkg::OFS_A_ACT_PACC || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("unmapped access without error");
	a_no_err_mapped: assert property (pready && paddr <= ean_pkg::OFS_A_ACT_PACC && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access flagged as error");
	a_reset_quiet: assert property ($past(rst) |-> !pready && !interrupt_out_one && event_out_n)
		else $error("outputs active right after reset");
	a_mask_off_irq: assert property (pready && pwrite && paddr == ean_pkg::OFS_IRQ_MASK && pwdata == 32'h0000_0000 |-> ##2 !interrupt_out_one)
		else $error("interrupt high with mask cleared");
	a_event_release: assert property (pready && pwrite && paddr == ean_pkg::OFS_EP_CONFIG && (!pwdata[4] || pwdata[3:1] == 3'h7) |-> ##[1:3] event_out_n)
		else $error("event pin low with event or detection off");

	////////////////////////////////////////////////////////////////////////
	c_error_seen: cover property (pslverr);
	c_event_low: cover property ($fell(event_out_n));
	c_irq_high: cover property ($rose(interrupt_out_one));
endmodule : ean_top_props

bind ean_top ean_top_props chk_u (
	.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.interrupt_out_one(interrupt_out_one), .event_out_n(event_out_n)
);
`default_nettype wire

// ==== tb/test_ean_top.sv ====
// Purpose: self-checking bench for the energy accumulation / no-load block
// Assumes: apb slave with one wait state, strobes driven by the bench
// Notes:   same power value on all three phases keeps expectations simple
`timescale 1ns/1ps
`default_nettype none
module test_ean_top;
	import ean_pkg::*;
	localparam logic [31:0] P  = 32'h0010_0000;
	localparam logic [31:0] NQ = 32'hFFD0_0000;
	localparam logic [31:0] EXP_M [4] = '{32'hFFFF_FF80, 32'h0000_0280,
		32'h0000_0100, 32'hFFFF_FE80};
	logic                    sys_clk, rst, psel, penable, pwrite;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata, r;
	logic                    pready, pslverr, e;
	logic                    sample_strobe, energy_update;
	logic [2:0][31:0]        act_p, rea_p, app_p, fre_p;
	logic                    interrupt_out_one, event_out_n;
	logic signed [41:0]      pa_exp;
	int                      err_count, check_count, i;

	ean_top dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_strobe(sample_strobe), .energy_update(energy_update),
		.active_power(act_p), .reactive_power(rea_p),
		.apparent_power(app_p), .fund_reactive_power(fre_p),
		.interrupt_out_one(interrupt_out_one), .event_out_n(event_out_n));

	always #2.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk

	// request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd_v, output logic er);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd_v = prdata;
		er   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		logic        te;
		apb(1'b1, a, d, t, te);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] t;
		logic        te;
		apb(1'b0, a, 32'h0, t, te);
		chk(t, x);
	endtask : rd

	// back-to-back strobes; tracks the free-running phase a power sum
	task automatic sample(input logic [31:0] a, input logic [31:0] q,
		input int n);
		repeat (n)
		begin
			act_p <= {3{a}};
			rea_p <= {3{q}};
			app_p <= {3{q}};
			fre_p <= {3{q}};
			sample_strobe <= 1'b1;
			@(posedge sys_clk);
			pa_exp = pa_exp + 42'(signed'(a));
		end
		sample_strobe <= 1'b0;
		@(posedge sys_clk);
	endtask : sample

	task automatic pulse_update();
		energy_update <= 1'b1;
		@(posedge sys_clk);
		energy_update <= 1'b0;
		@(posedge sys_clk);
	endtask : pulse_update

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#40000;
		err_count++;
		complete_run();
	end

	initial
	begin
		{sys_clk, psel, penable, pwrite, sample_strobe, energy_update} = '0;
		{paddr, pwdata, act_p, rea_p, app_p, fre_p} = '0;
		{err_count, check_count, pa_exp} = '0;
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (i = 0; i < 11; i++)
			rd(8'(i * 4), 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000, r, e);
		chk({31'h0, e}, 32'h0000_0001);
		chk(r, 32'h0000_0000);
		// each mode code on both fields, overwrite transfer
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_ACCUM_MODE, 32'(i * 5));
			wr(OFS_EP_CONFIG, 32'h0000_0001);
			pulse_update();
			sample(P, P, 2);
			sample(NQ, NQ, 1);
			pulse_update();
			rd(OFS_A_ACT_HIGH, EXP_M[i]);
			rd(OFS_A_REACT_HIGH, EXP_M[i]);
		end
		wr(OFS_ACCUM_MODE, 32'h0000_0000);
		wr(OFS_EP_CONFIG, 32'h0000_0000);
		sample(P, P, 2);
		pulse_update();
		rd(OFS_A_ACT_HIGH, 32'hFFFF_FF80);
		rd(OFS_A_REACT_HIGH, 32'hFFFF_FF80);
		// off then on restarts the window count
		wr(OFS_ACT_THRESH, 32'h0100_0000);
		wr(OFS_EP_CONFIG, 32'h0000_000E);
		wr(OFS_EP_CONFIG, 32'h0000_0011);
		sample(32'h0000_0001, 32'h0000_0000, 63);
		rd(OFS_NOLOAD_STAT, 32'h0000_0000);
		sample(32'h0000_0001, 32'h0000_0000, 1);
		rd(OFS_NOLOAD_STAT, 32'h0000_0049);
		rd(OFS_STATUS_TWO, 32'h0000_0001);
		chk({31'h0, event_out_n}, 32'h0000_0000);
		chk({31'h0, interrupt_out_one}, 32'h0000_0000);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		@(posedge sys_clk);
		chk({31'h0, interrupt_out_one}, 32'h0000_0001);
		pulse_update();
		sample(P, P, 8);
		pulse_update();
		rd(OFS_A_ACT_HIGH, 32'h0000_0000);
		rd(OFS_A_REACT_HIGH, 32'h0000_0400);
		rd(OFS_A_ACT_PACC, pa_exp[41:10]);
		wr(OFS_STATUS_TWO, 32'h0000_0001);
		rd(OFS_STATUS_TWO, 32'h0000_0000);
		chk({31'h0, interrupt_out_one}, 32'h0000_0000);
		wr(OFS_EP_CONFIG, 32'h0000_000E);
		rd(OFS_NOLOAD_STAT, 32'h0000_0000);
		chk({31'h0, event_out_n}, 32'h0000_0001);
		// leaving no-load is a change too, and the mask is still set
		chk({31'h0, interrupt_out_one}, 32'h0000_0001);
		wr(OFS_STATUS_TWO, 32'h0000_000F);
		wr(OFS_REACT_THRESH, 32'h0000_0001);
		wr(OFS_EP_CONFIG, 32'h0000_0002);
		sample(32'h0000_0001, 32'h0000_0000, 127);
		rd(OFS_NOLOAD_STAT, 32'h0000_0000);
		sample(32'h0000_0001, 32'h0000_0000, 1);
		rd(OFS_NOLOAD_STAT, 32'h0000_0EDB);
		rd(OFS_STATUS_TWO, 32'h0000_000B);
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, interrupt_out_one}, 32'h0000_0000);
		complete_run();
	end
endmodule : test_ean_top
`default_nettype wire
